//--- src/frt_defines.vh
// Constants for the free-running timer with two input capture channels.
// Assumes a byte-wide register map reached over a 32-bit AXI4-Lite slave.
`ifndef FRT_DEFINES_VH
`define FRT_DEFINES_VH

// Byte addresses of the registers, one aligned word each.
`define FRT_OFF_CTRL_ONE 6'h00
`define FRT_OFF_CTRL_TWO 6'h04
`define FRT_OFF_STATUS 6'h08
`define FRT_OFF_CAP1_HIGH 6'h0C
`define FRT_OFF_CAP1_LOW 6'h10
`define FRT_OFF_CAP2_HIGH 6'h14
`define FRT_OFF_CAP2_LOW 6'h18
`define FRT_OFF_COUNT_HIGH 6'h1C
`define FRT_OFF_COUNT_LOW 6'h20
`define FRT_OFF_SHADOW_HIGH 6'h24
`define FRT_OFF_SHADOW_LOW 6'h28

// Control one fields.
`define FRT_C1_CAP_IRQ_EN 7
`define FRT_C1_OVF_IRQ_EN 5
`define FRT_C1_CAP_EDGE 1
`define FRT_C1_MASK 8'hA2

// Control two fields.
`define FRT_C2_PWM_MODE 7
`define FRT_C2_ONE_PULSE 4
`define FRT_C2_CLK_SEL_HI 3
`define FRT_C2_CLK_SEL_LO 2
`define FRT_C2_CAP_EDGE 1
`define FRT_C2_EXT_EDGE 0
`define FRT_C2_MASK 8'h9F

// Status fields.
`define FRT_ST_CAP1_FLAG 7
`define FRT_ST_CAP2_FLAG 6
`define FRT_ST_OVF_FLAG 5

// Clock select codes and prescaler masks.
`define FRT_CS_DIV4 2'h0
`define FRT_CS_DIV2 2'h1
`define FRT_CS_DIV8 2'h2
`define FRT_CS_EXT 2'h3
`define FRT_PRE_MASK_DIV2 3'h1
`define FRT_PRE_MASK_DIV4 3'h3
`define FRT_PRE_MASK_DIV8 3'h7

// Reset and reload values.
`define FRT_COUNT_RELOAD 16'hFFFC
`define FRT_COUNT_TOP 16'hFFFF
`define FRT_CAP_RESET 16'h0000
`define FRT_CTRL_RESET 8'h00

// AXI responses.
`define FRT_RESP_OKAY 2'h0
`define FRT_RESP_SLVERR 2'h2

`endif

//--- src/frt_timer_capture.v
// Free-running 16-bit timer with prescaler, external clock and two input capture channels.
// Assumes an AXI4-Lite master on i_ref_clk, asynchronous pins, and the CPU interrupt mask as a level input.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "frt_defines.vh"

module frt_timer_capture #(
	parameter [2:0] BONDED = 3'h7
) (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_halt,
	input wire i_cpu_irq_mask,
	input wire i_ext_clock_pin,
	input wire i_capture_pin_one,
	input wire i_capture_pin_two,
	output wire o_timer_irq,
	input wire [7:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	output wire [1:0] o_s_axi_bresp,
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [7:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready
);

	reg [7:0] ctrl_one_r;
	reg [7:0] ctrl_two_r;
	reg [15:0] count_r;
	reg [15:0] count_nxt;
	reg [2:0] pre_r;
	reg [7:0] low_buf_r;
	reg low_buf_valid_r;
	reg ovf_flag_r;
	reg ovf_armed_r;
	reg aw_got_r;
	reg w_got_r;
	reg [7:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_lane0_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [1:0] rresp_r;
	reg [7:0] rdata_r;
	reg [7:0] rdata_nxt;
	reg rd_mapped;
	reg [2:0] pre_mask;

	wire [2:0] pin_raw;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;
	wire [1:0] cap_flag;
	// Capture values gathered from the per-channel generate loop.
	wire [31:0] cap_val_flat;

	// Register bus decode.
	wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
	wire wr_map = (aw_addr_r[7:6] == 2'h0);
	wire [5:0] wa = aw_addr_r[5:0];
	wire wr_en = wr_fire & wr_map & w_lane0_r;
	wire rd_fire = i_s_axi_arvalid & ~rvalid_r;
	wire rd_map = (i_s_axi_araddr[7:6] == 2'h0);
	wire [5:0] ra = i_s_axi_araddr[5:0];
	wire rd_ok = rd_fire & rd_map;

	wire rd_status = rd_ok & (ra == `FRT_OFF_STATUS);
	wire rd_cnt_hi = rd_ok & ((ra == `FRT_OFF_COUNT_HIGH) | (ra == `FRT_OFF_SHADOW_HIGH));
	wire rd_cnt_lo = rd_ok & (ra == `FRT_OFF_COUNT_LOW);
	wire rd_sh_lo = rd_ok & (ra == `FRT_OFF_SHADOW_LOW);
	wire wr_cnt_lo = wr_en & (wa == `FRT_OFF_COUNT_LOW);
	wire wr_sh_lo = wr_en & (wa == `FRT_OFF_SHADOW_LOW);
	wire [1:0] rd_cap_hi;
	wire [1:0] acc_cap_lo;
	wire [1:0] rd_cap_lo;
	assign rd_cap_hi[0] = rd_ok & (ra == `FRT_OFF_CAP1_HIGH);
	assign rd_cap_hi[1] = rd_ok & (ra == `FRT_OFF_CAP2_HIGH);
	assign rd_cap_lo[0] = rd_ok & (ra == `FRT_OFF_CAP1_LOW);
	assign rd_cap_lo[1] = rd_ok & (ra == `FRT_OFF_CAP2_LOW);
	assign acc_cap_lo[0] = rd_cap_lo[0] | (wr_en & (wa == `FRT_OFF_CAP1_LOW));
	assign acc_cap_lo[1] = rd_cap_lo[1] | (wr_en & (wa == `FRT_OFF_CAP2_LOW));

	// Mode and clock fields.
	wire [1:0] clk_sel = ctrl_two_r[`FRT_C2_CLK_SEL_HI:`FRT_C2_CLK_SEL_LO];
	wire pulse_modes = ctrl_two_r[`FRT_C2_ONE_PULSE] | ctrl_two_r[`FRT_C2_PWM_MODE];
	wire [1:0] cap_edge_sel = {ctrl_two_r[`FRT_C2_CAP_EDGE], ctrl_one_r[`FRT_C1_CAP_EDGE]};

	// Unbonded pins read as one.
	assign pin_raw[0] = BONDED[0] ? i_capture_pin_one : 1'b1;
	assign pin_raw[1] = BONDED[1] ? i_capture_pin_two : 1'b1;
	assign pin_raw[2] = BONDED[2] ? i_ext_clock_pin : 1'b1;

	// Three-flop synchronisers; a change counts once the second and third stages agree.
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_sync
			reg s1_r;
			reg s2_r;
			reg s3_r;
			reg lvl_r;
			always @(posedge i_ref_clk) begin
				if (!i_rst_n) begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					s3_r <= 1'b1;
					lvl_r <= 1'b1;
				end else begin
					s1_r <= pin_raw[k];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						lvl_r <= s3_r;
					end
				end
			end
			assign pin_rise[k] = (s2_r == s3_r) & s3_r & ~lvl_r;
			assign pin_fall[k] = (s2_r == s3_r) & ~s3_r & lvl_r;
		end
	endgenerate

	// Prescaler and counter clock enable.
	always @* begin
		case (clk_sel)
			`FRT_CS_DIV2: pre_mask = `FRT_PRE_MASK_DIV2;
			`FRT_CS_DIV4: pre_mask = `FRT_PRE_MASK_DIV4;
			`FRT_CS_DIV8: pre_mask = `FRT_PRE_MASK_DIV8;
			default: pre_mask = `FRT_PRE_MASK_DIV2;
		endcase
	end

	wire ext_edge = ctrl_two_r[`FRT_C2_EXT_EDGE] ? pin_rise[2] : pin_fall[2];
	wire pre_tick = ((pre_r & pre_mask) == pre_mask);
	wire cnt_tick = ~i_halt & ((clk_sel == `FRT_CS_EXT) ? ext_edge : pre_tick);
	wire cnt_reload = wr_cnt_lo | wr_sh_lo;
	wire ovf_set = cnt_tick & ~cnt_reload & (count_r == `FRT_COUNT_TOP);

	always @* begin
		count_nxt = count_r;
		if (cnt_reload) begin
			count_nxt = `FRT_COUNT_RELOAD;
		end else if (cnt_tick) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			count_r <= `FRT_COUNT_RELOAD;
			pre_r <= 3'h0;
		end else begin
			count_r <= count_nxt;
			if (!i_halt) begin
				pre_r <= pre_r + 3'h1;
			end
		end
	end

	// Overflow flag with two-step clear; a set in the clearing cycle wins.
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ovf_flag_r <= 1'b0;
			ovf_armed_r <= 1'b0;
		end else begin
			if (ovf_set) begin
				ovf_flag_r <= 1'b1;
			end else if (ovf_armed_r & (rd_cnt_lo | wr_cnt_lo)) begin
				ovf_flag_r <= 1'b0;
			end
			if (rd_status & ovf_flag_r) begin
				ovf_armed_r <= 1'b1;
			end else if (rd_cnt_lo | wr_cnt_lo) begin
				ovf_armed_r <= 1'b0;
			end
		end
	end

	// Low-byte buffer shared by the counter and its shadow.
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			low_buf_r <= 8'h00;
			low_buf_valid_r <= 1'b0;
		end else if (rd_cnt_hi & ~low_buf_valid_r) begin
			low_buf_r <= count_r[7:0];
			low_buf_valid_r <= 1'b1;
		end else if (rd_cnt_lo | rd_sh_lo) begin
			low_buf_valid_r <= 1'b0;
		end
	end

	// Capture channels.
	genvar j;
	generate
		for (j = 0; j < 2; j = j + 1) begin : g_cap
			reg [15:0] val_r;
			reg flag_r;
			reg armed_r;
			reg block_r;
			// A high-byte read freezes the channel until its low byte is read.
			wire edge_hit = cap_edge_sel[j] ? pin_rise[j] : pin_fall[j];
			wire enabled = (j == 1) | ~pulse_modes;
			wire cap_fire = edge_hit & enabled & ~block_r;
			always @(posedge i_ref_clk) begin
				if (!i_rst_n) begin
					val_r <= `FRT_CAP_RESET;
					flag_r <= 1'b0;
					armed_r <= 1'b0;
					block_r <= 1'b0;
				end else begin
					if (cap_fire) begin
						val_r <= count_r;
					end
					if (cap_fire) begin
						flag_r <= 1'b1;
					end else if (armed_r & acc_cap_lo[j]) begin
						flag_r <= 1'b0;
					end
					if (rd_status & flag_r) begin
						armed_r <= 1'b1;
					end else if (acc_cap_lo[j]) begin
						armed_r <= 1'b0;
					end
					if (rd_cap_hi[j]) begin
						block_r <= 1'b1;
					end else if (rd_cap_lo[j]) begin
						block_r <= 1'b0;
					end
				end
			end
			assign cap_flag[j] = flag_r;
			assign cap_val_flat[16*j+15:16*j] = val_r;
		end
	endgenerate

	// Interrupt request, held pending while masked or disabled.
	wire cap_req = ctrl_one_r[`FRT_C1_CAP_IRQ_EN] & (cap_flag[0] | cap_flag[1]);
	wire ovf_req = ctrl_one_r[`FRT_C1_OVF_IRQ_EN] & ovf_flag_r;
	assign o_timer_irq = ~i_cpu_irq_mask & (cap_req | ovf_req);

	// Control registers.
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			ctrl_one_r <= `FRT_CTRL_RESET;
			ctrl_two_r <= `FRT_CTRL_RESET;
		end else begin
			if (wr_en & (wa == `FRT_OFF_CTRL_ONE)) begin
				ctrl_one_r <= w_data_r & `FRT_C1_MASK;
			end
			if (wr_en & (wa == `FRT_OFF_CTRL_TWO)) begin
				ctrl_two_r <= w_data_r & `FRT_C2_MASK;
			end
		end
	end

	// Read data select.
	always @* begin
		rd_mapped = 1'b1;
		case (ra)
			`FRT_OFF_CTRL_ONE: rdata_nxt = ctrl_one_r;
			`FRT_OFF_CTRL_TWO: rdata_nxt = ctrl_two_r;
			`FRT_OFF_STATUS: rdata_nxt = {cap_flag[0], cap_flag[1], ovf_flag_r, 5'h00};
			`FRT_OFF_CAP1_HIGH: rdata_nxt = cap_val_flat[15:8];
			`FRT_OFF_CAP1_LOW: rdata_nxt = cap_val_flat[7:0];
			`FRT_OFF_CAP2_HIGH: rdata_nxt = cap_val_flat[31:24];
			`FRT_OFF_CAP2_LOW: rdata_nxt = cap_val_flat[23:16];
			`FRT_OFF_COUNT_HIGH: rdata_nxt = count_r[15:8];
			`FRT_OFF_SHADOW_HIGH: rdata_nxt = count_r[15:8];
			`FRT_OFF_COUNT_LOW: rdata_nxt = low_buf_valid_r ? low_buf_r : count_r[7:0];
			`FRT_OFF_SHADOW_LOW: rdata_nxt = low_buf_valid_r ? low_buf_r : count_r[7:0];
			default: begin
				rdata_nxt = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
		if (!rd_map) begin
			rd_mapped = 1'b0;
			rdata_nxt = 8'h00;
		end
	end

	// AXI4-Lite write channel.
	assign o_s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign o_s_axi_wready = ~w_got_r & ~bvalid_r;
	assign o_s_axi_bvalid = bvalid_r;
	assign o_s_axi_bresp = bresp_r;

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `FRT_RESP_OKAY;
		end else begin
			if (i_s_axi_awvalid & o_s_axi_awready) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid & o_s_axi_wready) begin
				w_got_r <= 1'b1;
				w_data_r <= i_s_axi_wdata[7:0];
				w_lane0_r <= i_s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_map && (wa <= `FRT_OFF_SHADOW_LOW) && (wa[1:0] == 2'h0) ?
					`FRT_RESP_OKAY : `FRT_RESP_SLVERR;
			end else if (bvalid_r & i_s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel.
	assign o_s_axi_arready = ~rvalid_r;
	assign o_s_axi_rvalid = rvalid_r;
	assign o_s_axi_rresp = rresp_r;
	assign o_s_axi_rdata = {24'h000000, rdata_r};

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rvalid_r <= 1'b0;
			rresp_r <= `FRT_RESP_OKAY;
			rdata_r <= 8'h00;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rdata_nxt;
			rresp_r <= rd_mapped ? `FRT_RESP_OKAY : `FRT_RESP_SLVERR;
		end else if (rvalid_r & i_s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule // frt_timer_capture

//--- verif/frt_pin_model.sv
// Pins outside the timer: external clock pin and two capture pins.
// Assumes toggle is called just after a rising clock edge.
`timescale 1ns/100ps
module frt_pin_model (
	input wire i_clk,
	output logic o_ext_clock_pin,
	output logic o_capture_pin_one,
	output logic o_capture_pin_two
);
	initial begin
		o_ext_clock_pin = 1'b1;
		o_capture_pin_one = 1'b1;
		o_capture_pin_two = 1'b1;
	end
	// Each transition is followed by eight clocks of quiet.
	task toggle(input integer p, input integer n);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				case (p)
					0: o_ext_clock_pin <= ~o_ext_clock_pin;
					1: o_capture_pin_one <= ~o_capture_pin_one;
					default: o_capture_pin_two <= ~o_capture_pin_two;
				endcase
				repeat (8) @(posedge i_clk);
			end
		end
	endtask
endmodule // frt_pin_model

//--- verif/frt_timer_capture_props.sv
// Bus and interrupt checks on the ports of the timer with input capture.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`include "frt_defines.vh"
module frt_timer_capture_props (
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_cpu_irq_mask,
	input wire o_timer_irq,
	input wire i_s_axi_awvalid,
	input wire o_s_axi_awready,
	input wire i_s_axi_wvalid,
	input wire o_s_axi_wready,
	input wire [1:0] o_s_axi_bresp,
	input wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire [31:0] o_s_axi_rdata,
	input wire [1:0] o_s_axi_rresp,
	input wire o_s_axi_rvalid,
	input wire i_s_axi_rready
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
		|-> ##2 o_s_axi_bvalid) else $error("write response not in two cycles");
	a_write_done: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("write response repeated");
	a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read data late");
	a_read_done: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
		else $error("read data repeated");
	a_ar_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken while busy");
	a_aw_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while busy");
	a_rdata_upper: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_irq_mask: assert property (i_cpu_irq_mask |-> !o_timer_irq) else $error("interrupt while masked");
	c_irq: cover property (o_timer_irq);
	c_wr_err: cover property (o_s_axi_bvalid && o_s_axi_bresp == `FRT_RESP_SLVERR);
	c_rd_err: cover property (o_s_axi_rvalid && o_s_axi_rresp == `FRT_RESP_SLVERR);
endmodule // frt_timer_capture_props

//--- verif/test_frt_timer_capture.sv
// Self-checking bench for the timer with input capture.
// Assumes the pin model drives the pins and the bench drives the bus.
`timescale 1ns/100ps
`include "frt_defines.vh"
module test_frt_timer_capture;
	logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_halt = 1'b1, i_cpu_irq_mask = 1'b0;
	logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0;
	logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
	logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
	wire ext, cap1, cap2, o_timer_irq, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
	wire [31:0] o_s_axi_rdata;
	integer fails = 0, check_count = 0, i;
	logic [31:0] d;
	logic [15:0] v, x;
	logic [1:0] r;
	logic [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h2C, 8'h08, 8'h0E};
	logic [7:0] rw [0:6] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0] re [0:6] = '{8'hA2, 8'h9F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [1:0] rr [0:6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2};
	logic [1:0] cs [0:2] = '{`FRT_CS_DIV2, `FRT_CS_DIV4, `FRT_CS_DIV8};
	frt_pin_model m_u (.i_clk(i_ref_clk), .o_ext_clock_pin(ext), .o_capture_pin_one(cap1), .o_capture_pin_two(cap2));
	frt_timer_capture dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_halt(i_halt),
		.i_cpu_irq_mask(i_cpu_irq_mask), .i_ext_clock_pin(ext), .i_capture_pin_one(cap1),
		.i_capture_pin_two(cap2), .o_timer_irq(o_timer_irq), .i_s_axi_awaddr(i_s_axi_awaddr),
		.i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
		.i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
		.o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
		.i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
		.o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
		.i_s_axi_rready(i_s_axi_rready));
	always #50 i_ref_clk = ~i_ref_clk;
	task final_report;
		begin
			$display("checks %0d mismatches %0d", check_count, fails);
			if (fails == 0 && check_count > 0) begin
				$display("Test passed");
			end else begin
				$display("Test failed");
			end
			$finish;
		end
	endtask
	task chk(input string s, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("BAD %s expected %h seen %h", s, e, g);
			end
		end
	endtask
	task give_up(input logic ok);
		begin
			if (!ok) begin
				chk("handshake", 32'h1, 32'h0);
				final_report;
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] dt);
		integer n;
		logic aw, w;
		begin
			aw = 1'b0;
			w = 1'b0;
			i_s_axi_awaddr <= a;
			i_s_axi_wdata <= {24'h0, dt};
			i_s_axi_awvalid <= 1'b1;
			i_s_axi_wvalid <= 1'b1;
			for (n = 0; n < 50 && !(aw && w); n = n + 1) begin
				@(posedge i_ref_clk);
				if (!aw && o_s_axi_awready === 1'b1) begin
					aw = 1'b1;
					i_s_axi_awvalid <= 1'b0;
				end
				if (!w && o_s_axi_wready === 1'b1) begin
					w = 1'b1;
					i_s_axi_wvalid <= 1'b0;
				end
			end
			give_up(aw && w);
			i_s_axi_bready <= 1'b1;
			aw = 1'b0;
			for (n = 0; n < 50 && !aw; n = n + 1) begin
				@(posedge i_ref_clk);
				aw = (o_s_axi_bvalid === 1'b1);
			end
			give_up(aw);
			r = o_s_axi_bresp;
			i_s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		integer n;
		logic t;
		begin
			i_s_axi_araddr <= a;
			i_s_axi_arvalid <= 1'b1;
			t = 1'b0;
			for (n = 0; n < 50 && !t; n = n + 1) begin
				@(posedge i_ref_clk);
				t = (o_s_axi_arready === 1'b1);
			end
			give_up(t);
			i_s_axi_arvalid <= 1'b0;
			i_s_axi_rready <= 1'b1;
			t = 1'b0;
			for (n = 0; n < 50 && !t; n = n + 1) begin
				@(posedge i_ref_clk);
				t = (o_s_axi_rvalid === 1'b1);
			end
			give_up(t);
			d = o_s_axi_rdata;
			r = o_s_axi_rresp;
			i_s_axi_rready <= 1'b0;
		end
	endtask
	task rchk(input [7:0] a, input [7:0] e);
		begin
			rd(a);
			chk($sformatf("reg %h", a), {24'h0, e}, d);
		end
	endtask
	task rd16(input [7:0] a);
		begin
			rd(a);
			v[15:8] = d[7:0];
			rd(a + 8'h04);
			v[7:0] = d[7:0];
		end
	endtask
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (i = 0; i < 7; i = i + 1) begin
			wr(ra[i], rw[i]);
			chk("write resp", 32'(rr[i]), 32'(r));
			rchk(ra[i], re[i]);
			chk("read resp", 32'(rr[i]), 32'(r));
		end
		$display("register table done");
		wr(8'h00, 8'h20);
		for (i = 0; i < 3; i = i + 1) begin
			x = 16'hFFFC + (16'h0040 >> (i + 1));
			wr(8'h04, {4'h0, cs[i], 2'h0});
			wr(8'h20, 8'h00);
			i_halt <= 1'b0;
			repeat (64) @(posedge i_ref_clk);
			i_halt <= 1'b1;
			rchk(8'h08, 8'h20);
			chk("irq", 32'h1, 32'(o_timer_irq));
			rd16(8'h24);
			chk("shadow", 32'(x), 32'(v));
			rchk(8'h08, 8'h20);
			rd16(8'h1C);
			chk("count", 32'(x), 32'(v));
			rchk(8'h08, 8'h00);
		end
		$display("prescaler test done");
		i_halt <= 1'b0;
		wr(8'h04, 8'h0D);
		wr(8'h20, 8'h00);
		m_u.toggle(0, 5);
		rd16(8'h1C);
		chk("ext rise", 32'hFFFE, 32'(v));
		rd(8'h1C);
		m_u.toggle(0, 2);
		rd(8'h1C);
		rchk(8'h20, 8'hFE);
		rchk(8'h20, 8'hFF);
		wr(8'h04, 8'h0C);
		wr(8'h28, 8'h00);
		m_u.toggle(0, 3);
		rd16(8'h1C);
		chk("ext fall", 32'hFFFD, 32'(v));
		$display("external clock test done");
		wr(8'h00, 8'h02);
		m_u.toggle(1, 1);
		m_u.toggle(2, 1);
		rchk(8'h08, 8'h40);
		m_u.toggle(1, 1);
		rchk(8'h08, 8'hC0);
		rd16(8'h0C);
		chk("cap one", 32'hFFFD, 32'(v));
		rchk(8'h08, 8'h40);
		m_u.toggle(0, 2);
		m_u.toggle(2, 2);
		rd16(8'h14);
		chk("cap two", 32'hFFFE, 32'(v));
		rchk(8'h08, 8'h00);
		rd(8'h0C);
		m_u.toggle(0, 2);
		m_u.toggle(1, 2);
		rchk(8'h08, 8'h00);
		rchk(8'h10, 8'hFD);
		m_u.toggle(1, 2);
		rchk(8'h08, 8'h80);
		rd16(8'h0C);
		chk("cap one", 32'hFFFF, 32'(v));
		wr(8'h04, 8'h1C);
		m_u.toggle(1, 2);
		m_u.toggle(2, 2);
		rchk(8'h08, 8'h40);
		wr(8'h00, 8'h82);
		chk("irq", 32'h1, 32'(o_timer_irq));
		i_cpu_irq_mask <= 1'b1;
		@(posedge i_ref_clk);
		chk("irq masked", 32'h0, 32'(o_timer_irq));
		i_cpu_irq_mask <= 1'b0;
		wr(8'h00, 8'h02);
		chk("irq off", 32'h0, 32'(o_timer_irq));
		wr(8'h00, 8'h82);
		chk("irq pending", 32'h1, 32'(o_timer_irq));
		wr(8'h04, 8'h8C);
		m_u.toggle(1, 2);
		rchk(8'h08, 8'h40);
		$display("capture test done");
		m_u.toggle(1, 2);
		m_u.toggle(2, 1);
		i_halt <= 1'b1;
		i_rst_n <= 1'b0;
		repeat (12) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		rchk(8'h00, 8'h00);
		rd16(8'h1C);
		chk("reset count", 32'hFFFC, 32'(v));
		rchk(8'h08, 8'h00);
		$display("reset test done");
		final_report;
	end
endmodule // test_frt_timer_capture
bind frt_timer_capture frt_timer_capture_props props_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_cpu_irq_mask(i_cpu_irq_mask), .o_timer_irq(o_timer_irq), .i_s_axi_awvalid(i_s_axi_awvalid),
	.o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
	.o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
	.i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
	.o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready));
